/* File: design/spi_client.sv */
// spi client shifter with multi-host select handling and apb registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module spi_client #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic [spi_client_pkg::BUS_W-1:0]    pwdata,
  output logic      [spi_client_pkg::BUS_W-1:0]    prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                sck_in,
  input  wire logic                                select_n_in,
  input  wire logic                                mosi_in,
  output logic                                     miso_out,
  output logic                                     miso_oe_n
);
  spi_client_pkg::state_t st_r;
  spi_client_pkg::state_t st_nxt;
  logic                   sck_s;
  logic                   ss_n_s;
  logic                   mosi_s;
  logic                   sel;
  logic                   done;
  logic                   acc;
  logic                   wr_data;
  logic                   preload;
  logic                   busy;
  logic [3:0]             idx;
  logic                   mapped;
  logic [spi_client_pkg::BYTE_W-1:0] rd_byte;
  logic [spi_client_pkg::BYTE_W-1:0] wbyte;

  // pin inputs are synchronised; select resets to deselected
  sync2 #(
    .W       (3),
    .RST_VAL (3'h2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sck_in, select_n_in, mosi_in}),
    .q       ({sck_s, ss_n_s, mosi_s})
  );

  assign idx   = paddr[spi_client_pkg::IDX_HI:spi_client_pkg::IDX_LO];
  assign wbyte = pwdata[spi_client_pkg::BYTE_W-1:0];

  always_comb
  begin
    mapped = (paddr[1:0] == 2'h0)
             && (paddr[ADDR_W-1:spi_client_pkg::IDX_HI+1] == '0)
             && (idx == spi_client_pkg::IDX_CONTROL_FIRST
                 || idx == spi_client_pkg::IDX_CONTROL_SECOND
                 || idx == spi_client_pkg::IDX_FLAGS
                 || idx == spi_client_pkg::IDX_DATA
                 || idx == spi_client_pkg::IDX_PIN_DIR);
    rd_byte = spi_client_pkg::BYTE_ZERO;
    case (idx)
      spi_client_pkg::IDX_CONTROL_FIRST:
      begin
        rd_byte[spi_client_pkg::CF_ORDER] = st_r.cfg.order;
        rd_byte[spi_client_pkg::CF_HOST]  = st_r.cfg.host;
        rd_byte[spi_client_pkg::CF_EN]    = st_r.cfg.enable;
      end
      spi_client_pkg::IDX_CONTROL_SECOND:
      begin
        rd_byte[spi_client_pkg::CS_BUF]  = st_r.cfg.buf_en;
        rd_byte[spi_client_pkg::CS_WAIT] = st_r.cfg.buf_wait;
        rd_byte[spi_client_pkg::CS_SDIS] = st_r.cfg.sel_dis;
      end
      spi_client_pkg::IDX_FLAGS:
      begin
        if (st_r.cfg.buf_en)
        begin
          rd_byte[spi_client_pkg::FL_RXC] = st_r.flg.rxc_f;
          rd_byte[spi_client_pkg::FL_TXC] = st_r.flg.txc_f;
          rd_byte[spi_client_pkg::FL_DRE] = !st_r.tx_full;
          rd_byte[spi_client_pkg::FL_OVF] = st_r.flg.ovf_f;
        end
        else
        begin
          rd_byte[spi_client_pkg::FL_IF]    = st_r.flg.if_f;
          rd_byte[spi_client_pkg::FL_COLL]  = st_r.flg.coll_f;
        end
      end
      spi_client_pkg::IDX_DATA:
        rd_byte = st_r.cfg.buf_en ? st_r.rx_mem[0] : st_r.rx_data;
      spi_client_pkg::IDX_PIN_DIR:
      begin
        rd_byte[spi_client_pkg::PD_SS_OUT]   = st_r.cfg.ss_out;
        rd_byte[spi_client_pkg::PD_MISO_OUT] = st_r.cfg.miso_dir;
      end
      default:
        rd_byte = spi_client_pkg::BYTE_ZERO;
    endcase
  end

  always_comb
  begin
    st_nxt  = st_r;
    done    = 1'b0;
    preload = 1'b0;
    acc     = psel && penable && st_r.apb.pready;
    wr_data = acc && pwrite && mapped && idx == spi_client_pkg::IDX_DATA;
    sel     = st_r.cfg.enable && !st_r.cfg.host && !ss_n_s;
    busy    = sel && st_r.bit_cnt != spi_client_pkg::CNT_ZERO;

    // apb: one setup cycle, answer in the first access cycle
    st_nxt.apb.pready  = psel && !penable;
    st_nxt.apb.pslverr = psel && !penable && !mapped;
    st_nxt.apb.prdata  = (psel && !penable && mapped && !pwrite)
                         ? {spi_client_pkg::PAD_ZERO, rd_byte}
                         : '0;

    st_nxt.sck_d = sck_s;
    st_nxt.done_d1 = 1'b0;
    st_nxt.done_d2 = st_r.done_d1;
    st_nxt.txc_p1  = 1'b0;
    st_nxt.txc_p2  = st_r.txc_p1;

    // software writes; flags are cleared first so hardware sets win
    if (acc && pwrite && mapped)
    begin
      case (idx)
        spi_client_pkg::IDX_CONTROL_FIRST:
        begin
          st_nxt.cfg.order  = pwdata[spi_client_pkg::CF_ORDER];
          st_nxt.cfg.host   = pwdata[spi_client_pkg::CF_HOST];
          st_nxt.cfg.enable = pwdata[spi_client_pkg::CF_EN];
        end
        spi_client_pkg::IDX_CONTROL_SECOND:
        begin
          st_nxt.cfg.buf_en   = pwdata[spi_client_pkg::CS_BUF];
          st_nxt.cfg.buf_wait = pwdata[spi_client_pkg::CS_WAIT];
          st_nxt.cfg.sel_dis  = pwdata[spi_client_pkg::CS_SDIS];
        end
        spi_client_pkg::IDX_FLAGS:
        begin
          if (st_r.cfg.buf_en)
          begin
            if (pwdata[spi_client_pkg::FL_RXC])
              st_nxt.flg.rxc_f = 1'b0;
            if (pwdata[spi_client_pkg::FL_TXC])
              st_nxt.flg.txc_f = 1'b0;
            if (pwdata[spi_client_pkg::FL_OVF])
              st_nxt.flg.ovf_f = 1'b0;
          end
          else
          begin
            if (pwdata[spi_client_pkg::FL_IF])
              st_nxt.flg.if_f = 1'b0;
            if (pwdata[spi_client_pkg::FL_COLL])
              st_nxt.flg.coll_f = 1'b0;
          end
        end
        spi_client_pkg::IDX_PIN_DIR:
        begin
          st_nxt.cfg.ss_out   = pwdata[spi_client_pkg::PD_SS_OUT];
          st_nxt.cfg.miso_dir = pwdata[spi_client_pkg::PD_MISO_OUT];
        end
        default:
          st_nxt.cfg = st_nxt.cfg;
      endcase
    end

    // reading data in buffered mode pops the receive fifo
    if (acc && !pwrite && mapped && idx == spi_client_pkg::IDX_DATA
        && st_r.cfg.buf_en && st_r.rx_cnt != spi_client_pkg::FIFO_NONE)
    begin
      st_nxt.rx_mem[0] = st_r.rx_mem[1];
      st_nxt.rx_cnt    = st_r.rx_cnt - spi_client_pkg::FIFO_ONE;
    end

    // client link: deselect halts and drops any partial byte
    case (st_r.link)
      spi_client_pkg::LINK_IDLE:
      begin
        st_nxt.bit_cnt = spi_client_pkg::CNT_ZERO;
        if (sel)
          st_nxt.link = spi_client_pkg::LINK_ACTIVE;
      end
      spi_client_pkg::LINK_ACTIVE:
      begin
        if (!sel)
        begin
          st_nxt.link    = spi_client_pkg::LINK_IDLE;
          st_nxt.bit_cnt = spi_client_pkg::CNT_ZERO;
        end
        else if (sck_s && !st_r.sck_d)
        begin
          // edges are only seen if each sck phase spans the sampler
          st_nxt.rx_bit  = mosi_s;
          st_nxt.bit_cnt = st_r.bit_cnt + spi_client_pkg::CNT_ONE;
        end
        else if (!sck_s && st_r.sck_d
                 && st_r.bit_cnt != spi_client_pkg::CNT_ZERO)
        begin
          st_nxt.shreg = st_r.cfg.order
                         ? {st_r.rx_bit, st_r.shreg[7:1]}
                         : {st_r.shreg[6:0], st_r.rx_bit};
          if (st_r.bit_cnt == spi_client_pkg::BYTE_BITS)
          begin
            done           = 1'b1;
            st_nxt.bit_cnt = spi_client_pkg::CNT_ZERO;
          end
        end
      end
      default:
        st_nxt.link = spi_client_pkg::LINK_IDLE;
    endcase

    if (done && !st_r.cfg.buf_en)
    begin
      st_nxt.flg.if_f = 1'b1;
      st_nxt.rx_data  = st_nxt.shreg;
    end
    else if (done)
    begin
      if (st_nxt.rx_cnt == spi_client_pkg::FIFO_FULL)
        st_nxt.flg.ovf_f = 1'b1;
      else
      begin
        st_nxt.rx_mem[st_nxt.rx_cnt[0]] = st_nxt.shreg;
        st_nxt.rx_cnt = st_nxt.rx_cnt + spi_client_pkg::FIFO_ONE;
      end
      st_nxt.done_d1 = 1'b1;
      if (st_r.tx_full)
      begin
        st_nxt.shreg    = st_r.tx_buf;
        st_nxt.tx_full  = 1'b0;
        st_nxt.sh_valid = 1'b1;
      end
      else
      begin
        st_nxt.sh_valid = 1'b0;
        st_nxt.txc_p1   = 1'b1;
      end
    end

    if (st_r.done_d1)
      st_nxt.flg.rxc_f = 1'b1;
    if (st_r.done_d2 && st_r.txc_p2)
      st_nxt.flg.txc_f = 1'b1;

    // with wait receive set, a deselected client loads user data at once
    preload = st_r.cfg.buf_en && st_r.cfg.buf_wait && !sel && !done
              && st_r.tx_full && !st_r.sh_valid;
    if (preload)
    begin
      st_nxt.shreg    = st_r.tx_buf;
      st_nxt.tx_full  = 1'b0;
      st_nxt.sh_valid = 1'b1;
    end

    // without preload the first byte out is the old shifter content
    if (wr_data && st_r.cfg.buf_en)
    begin
      if (!st_r.tx_full)
      begin
        st_nxt.tx_buf  = wbyte;
        st_nxt.tx_full = 1'b1;
      end
    end
    else if (wr_data)
    begin
      if (busy)
        st_nxt.flg.coll_f = 1'b1;
      else
        st_nxt.shreg = wbyte;
    end

    // competing host pulls select low: demote to client
    if (st_r.cfg.enable && st_r.cfg.host && !st_r.cfg.sel_dis
        && !st_r.cfg.ss_out && !ss_n_s)
    begin
      st_nxt.cfg.host = 1'b0;
      st_nxt.flg.if_f = 1'b1;
    end

    st_nxt.miso      = st_nxt.cfg.order ? st_nxt.shreg[0]
                                        : st_nxt.shreg[7];
    st_nxt.miso_oe_n = !(sel && st_r.cfg.miso_dir);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r           <= '0;
      st_r.link      <= spi_client_pkg::LINK_IDLE;
      st_r.miso_oe_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata    = st_r.apb.prdata;
  assign pready    = st_r.apb.pready;
  assign pslverr   = st_r.apb.pslverr;
  assign miso_out  = st_r.miso;
  assign miso_oe_n = st_r.miso_oe_n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_demote_host: assert property (st_r.cfg.enable && st_r.cfg.host
      && !st_r.cfg.sel_dis && !st_r.cfg.ss_out && !ss_n_s
      |=> !st_r.cfg.host && st_r.flg.if_f)
    else $error("host not demoted by low select");
  a_select_output: assert property (st_r.cfg.host && st_r.cfg.ss_out
      && !(acc && pwrite) |=> st_r.cfg.host)
    else $error("select as output changed host bit");
  a_select_disable: assert property (st_r.cfg.host
      && st_r.cfg.sel_dis && !(acc && pwrite) |=> st_r.cfg.host)
    else $error("disabled select changed host bit");
  a_idle_holds: assert property (!sel |=> st_r.bit_cnt == '0)
    else $error("bit count kept while deselected");
  a_byte_flag: assert property (done && !st_r.cfg.buf_en
      |=> st_r.flg.if_f && st_r.rx_data == $past(st_nxt.shreg))
    else $error("normal byte end without flag or data");
  // a shift edge in the same cycle legally moves the shifter
  a_write_collide: assert property (wr_data && busy
      && !st_r.cfg.buf_en && !done && sck_s == st_r.sck_d
      |=> st_r.flg.coll_f && $stable(st_r.shreg))
    else $error("collision write not dropped");
  a_full_drop: assert property (wr_data && st_r.cfg.buf_en
      && st_r.tx_full |=> $stable(st_r.tx_buf))
    else $error("full buffer overwritten");
  a_flag_chain: assert property (done && st_r.cfg.buf_en
      && !st_r.tx_full |=> ##1 st_r.flg.rxc_f ##1 st_r.flg.txc_f)
    else $error("receive and transfer flags out of order");
  a_txc_cause: assert property ($rose(st_r.flg.txc_f)
      |-> $past(st_r.flg.rxc_f) && $past(st_r.done_d2))
    else $error("transfer complete without receive complete");
  a_preload_next: assert property (preload
      |=> st_r.shreg == $past(st_r.tx_buf) && !st_r.tx_full)
    else $error("buffered byte not moved while deselected");
  a_miso_release: assert property (ss_n_s |=> st_r.miso_oe_n)
    else $error("data pin driven while deselected");

  c_normal_byte: cover property (done && !st_r.cfg.buf_en);
  c_buffer_txc: cover property ($rose(st_r.flg.txc_f));
  c_demotion: cover property ($fell(st_r.cfg.host) && st_r.flg.if_f);
  c_collision: cover property ($rose(st_r.flg.coll_f));
endmodule

/* File: design/sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: include/spi_client_pkg.sv */
// shared constants, register layout and state carriers for the spi client
// Functional notes
// - host, select enabled, pin input: low select clears host, sets if flag
// - host mode: select pin configured as output never affects the block; client mode ignores it
// - select disable at one: select pin ignored in host mode
// - client normal mode: deselected means idle, writes allowed, no shifting
// - once selected, shifting starts on the first sck pulse
// - client normal mode: if flag set after every complete byte
// - normal mode write during transfer dropped, write collision flag set
// - select rising halts shifting and discards any partial byte
// - buffer enable selects buffered mode with buffers and extra flags
// - buffered, wait receive zero: writes go to buffer, dummy byte first
// - the dummy byte is whatever the shift register already holds
// - buffered write while buffer full is dropped, buffer unchanged
// - buffer empty flag clears on buffer write, sets on move to shifter
// - receive complete set one cycle after buffer empty rises at end
// - transfer complete set one cycle after receive complete, all sent
// - wait receive one: user data shifts from select low, no dummy
// - wait receive one: byte written while deselected moves next cycle; here only if the shifter holds no unsent buffered byte
// - wait receive one: flag timing same as wait receive zero
// - client with output data pin: pin released while deselected
// - buffered: received bytes enter a two entry fifo, reads pop it
// - bit order zero sends msb first, one sends lsb first
package spi_client_pkg;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned BUS_W     = 32;
  localparam int unsigned RX_DEPTH  = 2;
  localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] FIFO_ONE  = 2'h1;
  localparam logic [1:0] FIFO_NONE = 2'h0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BUS_W-BYTE_W-1:0] PAD_ZERO = 24'h000000;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_CONTROL_FIRST  = 4'h0;
  localparam logic [3:0] IDX_CONTROL_SECOND = 4'h1;
  localparam logic [3:0] IDX_FLAGS          = 4'h3;
  localparam logic [3:0] IDX_DATA           = 4'h4;
  localparam logic [3:0] IDX_PIN_DIR        = 4'h5;
  localparam int unsigned IDX_LO = 2;
  localparam int unsigned IDX_HI = 5;
  // field positions
  localparam int unsigned CF_ORDER = 6;
  localparam int unsigned CF_HOST  = 5;
  localparam int unsigned CF_EN    = 0;
  localparam int unsigned CS_BUF   = 7;
  localparam int unsigned CS_WAIT  = 6;
  localparam int unsigned CS_SDIS  = 2;
  localparam int unsigned FL_IF    = 7;
  localparam int unsigned FL_COLL  = 6;
  localparam int unsigned FL_RXC   = 7;
  localparam int unsigned FL_TXC   = 6;
  localparam int unsigned FL_DRE   = 5;
  localparam int unsigned FL_OVF   = 0;
  localparam int unsigned PD_SS_OUT   = 0;
  localparam int unsigned PD_MISO_OUT = 1;

  typedef enum logic {LINK_IDLE, LINK_ACTIVE} link_t;

  typedef struct packed {
    logic order;
    logic host;
    logic enable;
    logic buf_en;
    logic buf_wait;
    logic sel_dis;
    logic ss_out;
    logic miso_dir;
  } config_t;

  typedef struct packed {
    logic if_f;
    logic coll_f;
    logic rxc_f;
    logic txc_f;
    logic ovf_f;
  } flags_t;

  typedef struct packed {
    logic [BUS_W-1:0] prdata;
    logic             pready;
    logic             pslverr;
  } apb_out_t;

  typedef struct packed {
    link_t                          link;
    config_t                        cfg;
    flags_t                         flg;
    logic [BYTE_W-1:0]              shreg;
    logic [CNT_W-1:0]               bit_cnt;
    logic                           rx_bit;
    logic                           sck_d;
    logic [BYTE_W-1:0]              rx_data;
    logic [BYTE_W-1:0]              tx_buf;
    logic                           tx_full;
    logic                           sh_valid;
    logic                           done_d1;
    logic                           done_d2;
    logic                           txc_p1;
    logic                           txc_p2;
    logic [RX_DEPTH-1:0][BYTE_W-1:0] rx_mem;
    logic [1:0]                     rx_cnt;
    apb_out_t                       apb;
    logic                           miso;
    logic                           miso_oe_n;
  } state_t;
endpackage

/* File: tb/spi_host_model.sv */
// external spi host model: drives sck, select and mosi, samples miso
`timescale 1ns/1ns
module spi_host_model (
  output logic       sck,
  output logic       select_n,
  output logic       mosi,
  input  wire logic  miso_line,
  output logic [7:0] rx_byte
);
  localparam int HALF = 160;
  event done;

  initial
  begin
    sck      = 1'b0;
    select_n = 1'b1;
    mosi     = 1'b0;
    rx_byte  = 8'h00;
  end

  // released mosi shows the inverse of its last level
  // pins move by non-blocking assignment so clock edges see no race
  task set_sel(input logic v);
    select_n <= v;
    if (v)
      mosi <= ~mosi;
  endtask

  // mode 0 frame; sck stands low outside it
  task xfer(input logic [7:0] tx, input int nbits);
    int i;
    select_n <= 1'b0;
    #(2*HALF);
    for (i = 0; i < nbits; i++)
    begin
      mosi <= tx[7-i];
      #(HALF) sck <= 1'b1;
      #(HALF-10) rx_byte = {rx_byte[6:0], miso_line};
      #10 sck <= 1'b0;
    end
    #(2*HALF);
    if (nbits == 8)
      -> done;
  endtask
endmodule

/* File: tb/tb_spi_client.sv */
// self-checking bench for the spi client block
`timescale 1ns/1ns
module tb_spi_client;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sck;
  logic        select_n;
  logic        mosi;
  logic        miso_out;
  logic        miso_oe_n;
  wire         miso_line;
  logic [7:0]  spi_rx;
  int          errors;
  int          compares;
  int          seed;
  int          i;
  logic [32:0] apb_q[$];
  logic [7:0]  spi_q[$];
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  ov_b[4];
  logic [7:0]  mh_b[3] = '{8'h00, 8'h04, 8'h00};
  logic [7:0]  mh_p[3] = '{8'h00, 8'h00, 8'h01};
  logic [7:0]  mh_e[3] = '{8'h01, 8'h21, 8'h21};
  logic [7:0]  mh_f[3] = '{8'h80, 8'h00, 8'h00};

  assign miso_line = miso_oe_n ? 1'bz : miso_out;

  spi_client spi_client_inst (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .sck_in      (sck),
    .select_n_in (select_n),
    .mosi_in     (mosi),
    .miso_out    (miso_out),
    .miso_oe_n   (miso_oe_n)
  );

  spi_host_model spi_host_model_inst (
    .sck       (sck),
    .select_n  (select_n),
    .mosi      (mosi),
    .miso_line (miso_line),
    .rx_byte   (spi_rx)
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rev(input logic [7:0] b);
    int k;
    for (k = 0; k < 8; k++)
      rev[k] = b[7-k];
  endfunction

  task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    apb_q.push_back(e);
    apb(a, 1'b0, 8'h00);
  endtask

  // one byte frame, then flags and fifo head, then clear flags
  task step(input logic [7:0] e, input logic [7:0] f);
    rx = $random(seed);
    spi_q.push_back(e);
    spi_host_model_inst.xfer(rx, 8);
    spi_host_model_inst.set_sel(1'b1);
    rd(8'h0c, {25'h0, f});
    rd(8'h10, {25'h0, rx});
    wr(8'h0c, 8'hc0);
  endtask

  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, apb_q.pop_front());

  always @(spi_host_model_inst.done)
    check({25'h0, spi_rx}, {25'h0, spi_q.pop_front()});

  task results;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #2000000;
    errors++;
    results;
  end

  initial
  begin
    seed     = 32'h110c;
    errors   = 0;
    compares = 0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h00000000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h0c, 33'h0);
    rd(8'h08, {1'b1, 32'h0});
    $display("test reset done");
    for (i = 0; i < 3; i++)
    begin
      wr(8'h04, mh_b[i]);
      wr(8'h14, mh_p[i]);
      wr(8'h00, 8'h21);
      spi_host_model_inst.set_sel(1'b0);
      repeat (8) @(posedge pclk);
      rd(8'h00, {25'h0, mh_e[i]});
      rd(8'h0c, {25'h0, mh_f[i]});
      spi_host_model_inst.set_sel(1'b1);
      wr(8'h0c, 8'hc0);
    end
    $display("test multi host done");
    wr(8'h14, 8'h02);
    wr(8'h04, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(8'h00, i ? 8'h41 : 8'h01);
      tx = $random(seed);
      rx = $random(seed);
      wr(8'h10, tx);
      spi_q.push_back(i ? rev(tx) : tx);
      fork
        spi_host_model_inst.xfer(rx, 8);
        begin
          repeat (30) @(posedge pclk);
          wr(8'h10, ~tx);
        end
      join
      spi_host_model_inst.set_sel(1'b1);
      rd(8'h0c, 33'hc0);
      rd(8'h10, {25'h0, i ? rev(rx) : rx});
      wr(8'h0c, 8'hc0);
    end
    $display("test normal done");
    wr(8'h00, 8'h01);
    tx = $random(seed);
    spi_host_model_inst.xfer(tx, 4);
    spi_host_model_inst.set_sel(1'b1);
    rd(8'h0c, 33'h0);
    tx = $random(seed);
    wr(8'h10, tx);
    step(tx, 8'h80);
    b2 = rx;
    $display("test abort done");
    wr(8'h04, 8'h80);
    b1 = $random(seed);
    wr(8'h10, b1);
    wr(8'h10, ~b1);
    rd(8'h0c, 33'h0);
    step(b2, 8'ha0);
    b2 = $random(seed);
    wr(8'h10, b2);
    step(b1, 8'ha0);
    step(b2, 8'he0);
    $display("test buffered wait0 done");
    wr(8'h04, 8'hc0);
    b1 = $random(seed);
    b2 = $random(seed);
    wr(8'h10, b1);
    wr(8'h10, b2);
    wr(8'h10, ~b2);
    step(b1, 8'ha0);
    step(b2, 8'he0);
    $display("test buffered wait1 done");
    // three frames without reads: the third byte overflows the fifo
    ov_b[0] = rx;
    for (i = 0; i < 3; i++)
    begin
      ov_b[i+1] = $random(seed);
      spi_q.push_back(ov_b[i]);
      spi_host_model_inst.xfer(ov_b[i+1], 8);
      spi_host_model_inst.set_sel(1'b1);
      repeat (8) @(posedge pclk);
    end
    rd(8'h0c, {25'h0, 8'he1});
    rd(8'h10, {25'h0, ov_b[1]});
    rd(8'h10, {25'h0, ov_b[2]});
    wr(8'h0c, 8'hc1);
    $display("test overflow done");
    results;
  end
endmodule
